/* File: urx_pkg.sv */
// shared constants and types for the serial receive status block
`default_nettype none
package urx_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STARTUP_NS = 64000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] STARTUP_LD = 12'(STARTUP_CYC);
  localparam logic [11:0] START_ZERO = 12'h000;
  localparam logic [11:0] START_STEP = 12'h001;
  localparam logic [7:0] BAUD_ZERO = 8'h00;
  localparam logic [7:0] BAUD_STEP = 8'h01;
  // sixteen-phase bit cell, three mid-cell samples
  localparam logic [3:0] OVS_FIRST = 4'h0;
  localparam logic [3:0] OVS_STEP = 4'h1;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam int TOP_BIT9 = 8;
  localparam int TOP_BIT8 = 7;
  // register byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CTRL1 = 5'h04;
  localparam logic [4:0] OFS_CTRL2 = 5'h08;
  localparam logic [4:0] OFS_CTRL3 = 5'h0c;
  localparam logic [4:0] OFS_BAUD = 5'h10;
  localparam logic [4:0] OFS_DATA = 5'h14;
  localparam logic [4:0] OFS_INTC = 5'h18;
  localparam logic [7:0] REG_RST = 8'h00;
  // control 1 fields
  localparam int C1_NINE = 0;
  localparam int C1_PAREN = 1;
  localparam int C1_PODD = 2;
  localparam int C1_TWOSTOP = 3;
  localparam int C1_MODE = 4;
  localparam int C1_UEN = 5;
  // control 2 fields
  localparam int C2_TEIE = 0;
  localparam int C2_TIIE = 1;
  localparam int C2_RIE = 2;
  localparam int C2_ADDEN = 3;
  localparam int C2_WAKE = 4;
  localparam int C2_RXEN = 5;
  // interrupt control fields
  localparam int IC_GIE = 0;
  localparam int IC_SUE = 1;
  // fifo
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] LVL_EMPTY = 2'd0;
  localparam logic [1:0] LVL_STEP = 2'd1;
  localparam logic [1:0] LVL_FULL = 2'd2;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2
  } urx_rxst_t;

  typedef struct packed {
    logic [8:0] data;
    logic noise;
    logic ferr;
    logic perr;
  } urx_entry_t;
endpackage
`default_nettype wire

/* File: urx_fifo_if.sv */
// carrier between the frame logic and the receive word fifo
`default_nettype none
interface urx_fifo_if;
  import urx_pkg::*;
  logic push;
  logic pop;
  urx_entry_t wrEnt;
  urx_entry_t rdEnt;
  logic [1:0] level;
  modport ctl(output push, output pop, output wrEnt, input rdEnt, input level);
  modport store(input push, input pop, input wrEnt, output rdEnt, output level);
endinterface
`default_nettype wire

/* File: urx_fifo.sv */
// two-entry receive word fifo, head at entry zero
`default_nettype none
module urx_fifo
  import urx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  urx_fifo_if.store fi
);
  typedef struct packed {
    urx_entry_t [FIFO_DEPTH-1:0] ent;
    logic [1:0] lvl;
  } urx_fifo_st_t;

  urx_fifo_st_t s;
  urx_fifo_st_t n;

  // pop shifts toward the head, then a push fills the first free slot
  always_comb begin
    n = s;
    if (fi.pop && s.lvl != LVL_EMPTY) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        n.ent[i] = s.ent[i+1];
      end
      n.lvl = s.lvl - LVL_STEP;
    end
    if (fi.push && n.lvl != LVL_FULL) begin
      n.ent[n.lvl[0]] = fi.wrEnt;
      n.lvl = n.lvl + LVL_STEP;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign fi.rdEnt = s.ent[0];
  assign fi.level = s.lvl;
endmodule
`default_nettype wire

/* File: urx_sampler.sv */
// three-sample majority vote on the receive pin within one bit cell
`default_nettype none
module urx_sampler
  import urx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic pin,
  input wire logic [3:0] ovs,
  output logic bitVal,
  output logic noisy,
  output logic decide
);
  typedef struct packed {
    logic s0;
    logic s1;
    logic bitv;
    logic noisy;
    logic dec;
  } urx_smp_st_t;

  urx_smp_st_t s;
  urx_smp_st_t n;

  // samples at phases 7 and 8, vote at phase 9
  always_comb begin
    n = s;
    n.dec = 1'b0;
    if (tick && ovs == SMP_A) begin
      n.s0 = pin;
    end else if (tick && ovs == SMP_B) begin
      n.s1 = pin;
    end else if (tick && ovs == SMP_C) begin
      n.bitv = (s.s0 & s.s1) | (s.s0 & pin) | (s.s1 & pin);
      n.noisy = !(s.s0 == s.s1 && s.s1 == pin);
      n.dec = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bitVal = s.bitv;
  assign noisy = s.noisy;
  assign decide = s.dec;
endmodule
`default_nettype wire

/* File: urx_uart_rx.sv */
// serial receive status, errors, interrupt merge and pin wake-up
// Function
// - word into buffer sets avail, requests interrupt
// - two-word fifo; third word flags overrun
// - overrun clears on status then data read
// - noise flagged with word, no own interrupt
// - noise clears on status then data read
// - low stop bit sets framing error
// - any reset clears framing and parity errors
// - parity mismatch flagged only when parity enabled
// - six conditions merge into one low pulse
// - vector needs both enables, stack not full
// - own transmit enables; receive, overrun and wake share the receive enable, address word does not use it
// - address word interrupts when detect enabled
// - detect mode interrupts only on top bit
// - detect off: every word interrupts
// - status flags ignore software writes
// - stopped clock halts baud ticks, reception and start-up count
// - low power keeps all registers unchanged
// - pin falling edge wakes with clock off
// - ignore pin and hold wake interrupt during start-up
// - wake without enables raises no interrupt
// - sixteen-times sampling, majority of three
// - avail clears on status then data read
`default_nettype none
module urx_uart_rx
  import urx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxTxPin,
  input wire logic uartClkOn,
  input wire logic txEmptyFlag,
  input wire logic txIdleFlag,
  input wire logic stackFull,
  input wire logic intAck,
  output logic usimIntReqN,
  output logic vectorReq,
  output logic sysWake
);
  typedef struct packed {
    urx_rxst_t st;
    logic [3:0] ovs;
    logic [3:0] bitCnt;
    logic [8:0] sh;
    logic parAcc;
    logic noise;
    logic ferr;
    logic perr;
    logic pinPrev;
    logic wPin;
    logic push;
    urx_entry_t ent;
    logic pop;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] baud;
    logic [7:0] baudCnt;
    logic tick;
    logic gie;
    logic sue;
    logic seen;
    logic oerr;
    logic ack;
    logic [31:0] datO;
    logic irqN;
    logic pend;
    logic vec;
    logic wake;
    logic wakePend;
    logic [11:0] startCnt;
    logic txEPrev;
    logic txIPrev;
  } urx_top_st_t;

  urx_top_st_t s;
  urx_top_st_t n;

  urx_fifo_if fi();

  logic smpBit;
  logic smpNoisy;
  logic smpDec;
  logic run;
  logic rxEnCfg;
  logic rxOn;
  logic nine;
  logic req;
  logic rdReq;
  logic clrSeq;
  logic fifoEmpty;
  logic accept;
  logic overrun;
  logic topBit;
  logic rxEv;
  logic ovEv;
  logic adEv;
  logic teEv;
  logic tiEv;
  logic wkEv;
  logic wkCond;
  logic nz;
  logic fe;
  logic [3:0] lastBit;
  logic [7:0] statusByte;
  logic [7:0] rdByte;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  assign fi.push = s.push;
  assign fi.pop = s.pop;
  assign fi.wrEnt = s.ent;

  urx_fifo uFifo (
    .clk(clk),
    .rst(rst),
    .fi(fi)
  );

  urx_sampler uSmp (
    .clk(clk),
    .rst(rst),
    .tick(s.tick && rxOn),
    .pin(rxTxPin),
    .ovs(s.ovs),
    .bitVal(smpBit),
    .noisy(smpNoisy),
    .decide(smpDec)
  );

  ////////////////////////////////////////////////////////////////////////
  // helper terms

  // halted while clock off or still starting up
  assign run = uartClkOn && s.startCnt == START_ZERO;
  assign rxEnCfg = s.ctrl1[C1_MODE] && s.ctrl1[C1_UEN] && s.ctrl2[C2_RXEN];
  assign rxOn = run && rxEnCfg;
  assign nine = s.ctrl1[C1_NINE];
  assign lastBit = nine ? LAST_BIT9 : LAST_BIT8;
  assign nz = s.noise | smpNoisy;
  assign fe = s.ferr | !smpBit;

  // bus request and the status-then-data clearing sequence
  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign rdReq = req && !wb_we_i;
  assign clrSeq = rdReq && wb_adr_i == OFS_DATA && s.seen;
  assign fifoEmpty = fi.level == LVL_EMPTY;

  // full fifo keeps its words, the new one is dropped
  assign accept = s.push && (fi.level != LVL_FULL || s.pop);
  assign overrun = s.push && !accept;
  assign topBit = nine ? s.ent.data[TOP_BIT9] : s.ent.data[TOP_BIT8];

  // interrupt sources, noise adds none of its own
  assign rxEv = accept && s.ctrl2[C2_RIE] &&
                (!s.ctrl2[C2_ADDEN] || topBit);
  assign ovEv = overrun && s.ctrl2[C2_RIE];
  assign adEv = accept && s.ctrl2[C2_ADDEN] && topBit;
  assign teEv = txEmptyFlag && !s.txEPrev && s.ctrl2[C2_TEIE];
  assign tiEv = txIdleFlag && !s.txIPrev && s.ctrl2[C2_TIIE];
  assign wkEv = s.wakePend && run;

  // falling pin edge while the clock is off
  assign wkCond = !uartClkOn && s.wPin && !rxTxPin && s.ctrl2[C2_WAKE] && rxEnCfg &&
                  s.ctrl2[C2_RIE];

  // framing, noise and parity flags come from the head word
  assign statusByte = {txEmptyFlag, txIdleFlag, !fifoEmpty, s.st == RX_IDLE, s.oerr,
                       fi.rdEnt.ferr, fi.rdEnt.noise, fi.rdEnt.perr};

  // read data mux, unmapped reads as zero
  assign rdByte = (wb_adr_i == OFS_STATUS) ? statusByte :
                  (wb_adr_i == OFS_CTRL1) ? {fi.rdEnt.data[TOP_BIT9], s.ctrl1[6:0]} :
                  (wb_adr_i == OFS_CTRL2) ? s.ctrl2 :
                  (wb_adr_i == OFS_CTRL3) ? s.ctrl3 :
                  (wb_adr_i == OFS_BAUD) ? s.baud :
                  (wb_adr_i == OFS_DATA) ? fi.rdEnt.data[7:0] :
                  (wb_adr_i == OFS_INTC) ? {6'h00, s.sue, s.gie} : REG_RST;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.push = 1'b0;
    n.pop = 1'b0;
    n.tick = 1'b0;
    n.irqN = 1'b1;
    n.wake = 1'b0;
    n.wPin = rxTxPin;
    n.txEPrev = txEmptyFlag;
    n.txIPrev = txIdleFlag;

    // sixteen-times baud enable, frozen while halted
    if (run) begin
      if (s.baudCnt == BAUD_ZERO) begin
        n.tick = 1'b1;
        n.baudCnt = s.baud;
      end else begin
        n.baudCnt = s.baudCnt - BAUD_STEP;
      end
    end

    // start-up delay after a wake
    if (uartClkOn && s.startCnt != START_ZERO) begin
      n.startCnt = s.startCnt - START_STEP;
    end

    // bit cell phase and start edge search
    if (!rxEnCfg) begin
      n.st = RX_IDLE;
    end else if (s.tick && rxOn) begin
      n.pinPrev = rxTxPin;
      n.ovs = s.ovs + OVS_STEP;
      if (s.st == RX_IDLE && s.pinPrev && !rxTxPin) begin
        n.st = RX_START;
        n.ovs = OVS_FIRST;
        n.bitCnt = OVS_FIRST;
        n.sh = '0;
        n.parAcc = 1'b0;
        n.noise = 1'b0;
        n.ferr = 1'b0;
        n.perr = 1'b0;
      end
    end

    // frame sequencing on each voted bit
    if (smpDec && rxOn) begin
      unique case (s.st)
        RX_IDLE: begin
        end
        RX_START: begin
          if (smpBit) begin
            n.st = RX_IDLE;
          end else begin
            n.st = RX_DATA;
            n.noise = smpNoisy;
          end
        end
        RX_DATA: begin
          n.sh = {smpBit, s.sh[8:1]};
          n.parAcc = s.parAcc ^ smpBit;
          n.noise = nz;
          n.bitCnt = s.bitCnt + OVS_STEP;
          if (s.bitCnt == lastBit) begin
            n.st = s.ctrl1[C1_PAREN] ? RX_PAR : RX_STOP1;
          end
        end
        RX_PAR: begin
          n.perr = s.parAcc ^ smpBit ^ s.ctrl1[C1_PODD];
          n.noise = nz;
          n.st = RX_STOP1;
        end
        RX_STOP1, RX_STOP2: begin
          if (s.st == RX_STOP1 && s.ctrl1[C1_TWOSTOP]) begin
            n.ferr = fe;
            n.noise = nz;
            n.st = RX_STOP2;
          end else begin
            // word stored even with errors
            n.push = 1'b1;
            n.ent.data = nine ? s.sh : {1'b0, s.sh[8:1]};
            n.ent.noise = nz;
            n.ent.ferr = fe;
            n.ent.perr = s.perr;
            n.st = RX_IDLE;
          end
        end
      endcase
    end

    // bus slave, one wait state
    if (req) begin
      n.ack = 1'b1;
      if (wb_adr_i == OFS_STATUS) begin
        n.seen = 1'b1;
      end
      if (wb_we_i && wb_sel_i[0]) begin
        // status writes fall through untouched
        unique case (wb_adr_i)
          OFS_CTRL1: n.ctrl1 = wb_dat_i[7:0];
          OFS_CTRL2: n.ctrl2 = wb_dat_i[7:0];
          OFS_CTRL3: n.ctrl3 = wb_dat_i[7:0];
          OFS_BAUD: n.baud = wb_dat_i[7:0];
          OFS_INTC: begin
            n.gie = wb_dat_i[IC_GIE];
            n.sue = wb_dat_i[IC_SUE];
          end
          default: begin
          end
        endcase
      end
      if (!wb_we_i) begin
        n.datO = 32'(rdByte);
        if (wb_adr_i == OFS_DATA) begin
          n.seen = 1'b0;
          n.pop = clrSeq && !fifoEmpty;
        end
      end
    end

    // overrun flag, a new overrun beats the clear
    n.oerr = (s.oerr && !clrSeq) || overrun;

    // pin wake, interrupt held until start-up ends
    if (wkCond) begin
      n.wake = 1'b1;
      n.startCnt = STARTUP_LD;
      n.wakePend = s.wakePend || (s.gie && s.sue);
    end else if (wkEv) begin
      n.wakePend = 1'b0;
    end

    // merged low pulse and latched request
    if (rxEv || ovEv || adEv || teEv || tiEv || wkEv) begin
      n.irqN = 1'b0;
    end
    n.pend = (s.pend && !intAck) || !n.irqN;
    n.vec = s.pend && !intAck && s.gie && s.sue && !stackFull;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, untouched by clock stop

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.irqN <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = s.datO;
  assign wb_ack_o = s.ack;
  assign usimIntReqN = s.irqN;
  assign vectorReq = s.vec;
  assign sysWake = s.wake;
endmodule
`default_nettype wire

/* File: urx_uart_rx_props.sv */
// concurrent checks on the ports of the serial receive status block
`default_nettype none
module urx_uart_rx_props
  import urx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rxTxPin,
  input wire logic uartClkOn,
  input wire logic txEmptyFlag,
  input wire logic txIdleFlag,
  input wire logic stackFull,
  input wire logic intAck,
  input wire logic usimIntReqN,
  input wire logic vectorReq,
  input wire logic sysWake
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] wakeCnt_r;
  ////////////////////////////////////////////////////////////////
  // start-up cycles left after a pin wake
  always_ff @(posedge clk) begin
    if (rst) wakeCnt_r <= 12'h000;
    else if (sysWake) wakeCnt_r <= STARTUP_LD;
    else if (uartClkOn && wakeCnt_r != 12'h000) wakeCnt_r <= wakeCnt_r - 12'h001;
  end
  ////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_wait_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing");
  irq_pulse_a: assert property (!usimIntReqN |=> usimIntReqN)
    else $error("irq pulse too long");
  vector_gate_a: assert property (vectorReq |-> !$past(stackFull) && !$past(intAck))
    else $error("vector while blocked");
  wake_off_a: assert property (sysWake |-> !$past(uartClkOn))
    else $error("wake with clock on");
  wake_pin_a: assert property (sysWake |-> !$past(rxTxPin))
    else $error("wake without low pin");
  wake_pulse_a: assert property (sysWake |=> !sysWake)
    else $error("wake pulse too long");
  startup_quiet_a: assert property (wakeCnt_r > 12'h002 |-> usimIntReqN)
    else $error("irq during start-up");
  reset_quiet_a: assert property ($past(rst) |-> usimIntReqN && !vectorReq && !sysWake)
    else $error("outputs active after reset");
endmodule
bind urx_uart_rx urx_uart_rx_props props_i (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .rxTxPin, .uartClkOn, .txEmptyFlag,
  .txIdleFlag, .stackFull, .intAck, .usimIntReqN, .vectorReq, .sysWake);
`default_nettype wire

/* File: urx_tx_model.sv */
// remote serial transmitter driving the receive pin
`default_nettype none
module urx_tx_model (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin = 1'b1;
  ////////////////////////////////////////////////////////////////
  // sixteen clocks a bit, lsb first; gl flips one clock for noise
  task automatic send(input logic [12:0] f, input int gl);
    for (int i = 0; i < 208; i++) begin
      @(posedge clk);
      pin <= (i == gl) ? !f[i / 16] : f[i / 16];
    end
    @(posedge clk);
    pin <= 1'b1; // idle high between frames
  endtask
endmodule
`default_nettype wire

/* File: tb_urx_uart_rx.sv */
// self-checking bench for the serial receive status block
`default_nettype none
module tb_urx_uart_rx
  import urx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic clkOn = 1'b1, txE = 1'b0, txI = 1'b0, stkF = 1'b0, iAck = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, rdat;
  logic ack, irqN, vReq, wake, pin;
  logic [7:0] q;
  logic [5:0] c1 = 6'h00;
  int n_mismatch = 0, checks = 0, irqs = 0, wakes = 0, ticks = 0;
  initial forever #12.5 clk = ~clk;
  urx_uart_rx DUT (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rxTxPin(pin), .uartClkOn(clkOn), .txEmptyFlag(txE), .txIdleFlag(txI),
    .stackFull(stkF), .intAck(iAck), .usimIntReqN(irqN), .vectorReq(vReq), .sysWake(wake));
  urx_tx_model tx (.clk(clk), .pin(pin));
  ////////////////////////////////////////////////////////////////
  // event counters and hang guard
  always @(posedge clk) begin
    irqs <= irqs + int'(irqN === 1'b0);
    wakes <= wakes + int'(wake === 1'b1);
    ticks <= ticks + 1;
    if (ticks == 30000) begin
      fail("timeout");
      conclude();
    end
  end
  task automatic fail(input string m);
    $display("unexpected %0t %s", $time, m);
    n_mismatch++;
  endtask
  task automatic chkB(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e) fail(m);
  endtask
  task automatic chkN(input int g, input int e, input string m);
    checks++;
    if (g != e) fail(m);
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // one classic wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t == 20) fail("no ack");
    repeat (2) @(posedge clk);
  endtask
  task automatic cfg(input logic [5:0] a, input logic [7:0] b);
    c1 = a;
    bus(1'b1, OFS_CTRL1, {2'h0, a});
    bus(1'b1, OFS_CTRL2, b);
  endtask
  // frame bits: start, data, parity, stops, then idle ones
  function automatic logic [12:0] fr(input logic [8:0] d, input logic [1:0] sv, input logic bp);
    logic [12:0] f;
    int k;
    f = 13'h1fff;
    f[0] = 1'b0;
    k = c1[C1_NINE] ? 9 : 8;
    for (int i = 0; i < k; i++) f[i + 1] = d[i];
    if (c1[C1_PAREN]) begin
      f[k + 1] = ^(d & (c1[C1_NINE] ? 9'h1ff : 9'h0ff)) ^ c1[C1_PODD] ^ bp;
      k++;
    end
    f[k + 1] = sv[0];
    if (c1[C1_TWOSTOP]) f[k + 2] = sv[1];
    return f;
  endfunction
  task automatic rx(input logic [8:0] d, input logic [1:0] sv, input logic bp, input int gl);
    tx.send(fr(d, sv, bp), gl);
    repeat (6) @(posedge clk);
  endtask
  // status access then data read, both compared
  task automatic pop(input logic [7:0] m, input logic [7:0] e, input logic [7:0] d);
    bus(1'b0, OFS_STATUS, 8'h00);
    chkB(q & m, e, "status");
    bus(1'b0, OFS_DATA, 8'h00);
    chkB(q, d, "data");
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [8:0] d;
    int n0, w0;
    void'($urandom(62913));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, OFS_INTC, 8'h03);
    cfg(6'h30, 8'h24);
    for (int i = 0; i < 4; i++) begin
      d = 9'($urandom);
      n0 = irqs;
      rx(d, 2'h3, 1'b0, -1);
      chkN(irqs - n0, 1, "rx irq");
      bus(1'b1, OFS_STATUS, 8'hff);
      pop(8'h2f, 8'h20, d[7:0]);
      bus(1'b0, OFS_STATUS, 8'h00);
      chkB(q & 8'h20, 8'h00, "avail");
    end
    n0 = irqs;
    rx(9'h0a5, 2'h0, 1'b0, -1);
    rx(9'h03c, 2'h3, 1'b0, -1);
    rx(9'h0ff, 2'h3, 1'b0, -1);
    chkN(irqs - n0, 3, "overrun irq");
    pop(8'h0c, 8'h0c, 8'ha5);
    pop(8'h2f, 8'h20, 8'h3c);
    n0 = irqs;
    d = 9'($urandom);
    rx(d, 2'h3, 1'b0, 40);
    chkN(irqs - n0, 1, "noise irq");
    pop(8'h02, 8'h02, d[7:0]);
    bus(1'b0, OFS_STATUS, 8'h00);
    chkB(q & 8'h02, 8'h00, "noise");
    for (int i = 0; i < 4; i++) begin
      cfg({2'h3, 1'h0, i[0], 2'h2}, 8'h24);
      d = 9'($urandom);
      rx(d, 2'h3, i[1], -1);
      pop(8'h01, {7'h00, i[1]}, d[7:0]);
    end
    cfg(6'h38, 8'h24);
    for (int i = 0; i < 2; i++) begin
      d = 9'($urandom);
      rx(d, {i[0], 1'h1}, 1'b0, -1);
      pop(8'h04, {5'h00, !i[0], 2'h0}, d[7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      cfg({5'h18, i[1]}, 8'h2c);
      d = 9'($urandom);
      if (i[1]) d[8] = i[0];
      else d[7] = i[0];
      n0 = irqs;
      rx(d, 2'h3, 1'b0, -1);
      chkN(irqs - n0, int'(i[0]), "addr irq");
      if (i[1]) begin
        bus(1'b0, OFS_CTRL1, 8'h00);
        chkB(q & 8'h80, {d[8], 7'h00}, "ninth bit");
      end
      pop(8'h00, 8'h00, d[7:0]);
    end
    cfg(6'h30, 8'h25);
    iAck <= 1'b1;
    @(posedge clk);
    iAck <= 1'b0;
    n0 = irqs;
    txE <= 1'b1;
    txI <= 1'b1;
    repeat (4) @(posedge clk);
    chkN(irqs - n0, 1, "tx irq");
    chkB(8'(vReq), 8'h01, "vector");
    stkF <= 1'b1;
    repeat (3) @(posedge clk);
    chkB(8'(vReq), 8'h00, "stack full");
    stkF <= 1'b0;
    cfg(6'h30, 8'h34);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, OFS_INTC, {6'h00, {2{!i[0]}}});
      n0 = irqs;
      w0 = wakes;
      clkOn <= 1'b0;
      rx(9'h000, 2'h3, 1'b0, -1);
      clkOn <= 1'b1;
      chkN(wakes - w0, 1, "wake");
      repeat (STARTUP_CYC - 20) @(posedge clk);
      chkN(irqs - n0, 0, "early irq");
      repeat (60) @(posedge clk);
      chkN(irqs - n0, 1 - i, "wake irq");
      bus(1'b0, OFS_STATUS, 8'h00);
      chkB(q & 8'h20, 8'h00, "ignored");
      bus(1'b0, OFS_CTRL2, 8'h00);
      chkB(q, 8'h34, "ctrl kept");
    end
    cfg(6'h30, 8'h24);
    rx(9'h055, 2'h0, 1'b0, -1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_STATUS, 8'h00);
    chkB(q & 8'h2f, 8'h00, "reset");
    conclude();
  end
endmodule
`default_nettype wire
